// ---- design/tdc_regs.vh ----
`ifndef TDC_REGS_VH
`define TDC_REGS_VH

// ---------------------------------------------------------------
// register indexes (byte address = 4 * index)
// ---------------------------------------------------------------
`define TDC_IDX_GAIN_B 10'h07B
`define TDC_IDX_REF_TRIM 10'h07C
`define TDC_IDX_TERM_A 10'h07E
`define TDC_IDX_TERM_B 10'h07F
`define TDC_IDX_DITHER 10'h09D
`define TDC_IDX_BANK0_SKEW 10'h102

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define TDC_REF_TRIM_MSB 3
`define TDC_DITH_ON_BIT 0
`define TDC_DITH_LEVEL_BIT 1
`define TDC_DITH_ROUND_BIT 2
`define TDC_DITHER_RESET 8'h01

// ---------------------------------------------------------------
// fuse storage slots, loaded in this order after reset
// ---------------------------------------------------------------
`define TDC_FUSE_GAIN_B 3'h0
`define TDC_FUSE_REF_TRIM 3'h1
`define TDC_FUSE_TERM_A 3'h2
`define TDC_FUSE_TERM_B 3'h3
`define TDC_FUSE_BANK0_SKEW 3'h4
`define TDC_FUSE_LAST 3'h4

`endif

// ---- design/tdc_trim_dither_config_regs.v ----
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
// What this block does
// - channel B gain trim, eight bits, read/write
// - reference trim bits 3-0, upper bits zero
// - input A termination trim register, read/write
// - input B termination trim register, read/write
// - dither enable bit 0, resets on
// - bit 1 picks small or large dither
// - bit 2 routes dither rounding error
// - bank zero skew register, fuse loaded
// - reference trim reset value comes from fuses
// - gain trim B sits at index 0x07B
`include "tdc_regs.vh"

module tdc_trim_dither_config_regs (
    input wire core_clk,
    input wire reset_n,
    input wire coreEn,
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [11:0] wbAdr,
    input wire [3:0] wbSel,
    input wire [31:0] wbDatIn,
    output reg [31:0] wbDatOut,
    output reg wbAck,
    output reg [2:0] fuseAddr,
    input wire [7:0] fuseData,
    output reg loadDone,
    output reg [7:0] channelBGainTrim,
    output reg [3:0] referenceVoltageAdjust,
    output reg [7:0] inputATerminationAdjust,
    output reg [7:0] inputBTerminationAdjust,
    output reg ditherOn,
    output reg ditherLevelSel,
    output reg roundingErrorSel,
    output reg [7:0] bankZeroPhaseZeroSkew
);

    // ---------------------------------------------------------------
    // fuse load sequencer
    // ---------------------------------------------------------------
    // two cycles per slot: address out, then capture on the next edge
    localparam ST_ADDR = 2'b00;
    localparam ST_CAPT = 2'b01;
    localparam ST_IDLE = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    wire reqLive;
    wire [9:0] regIdx;
    wire wrEn;
    reg [7:0] readByte;
    // capture cycle flag and per-register write strobes
    wire fuseCapt;
    wire wrGainB;
    wire wrRefTrim;
    wire wrTermA;
    wire wrTermB;
    wire wrDither;
    wire wrSkew;

    // dither control reset pattern, split into its fields below
    localparam [7:0] DITHER_RESET = `TDC_DITHER_RESET;

    // ---------------------------------------------------------------
    // decode helpers and strobes
    // ---------------------------------------------------------------

    // register index from the byte address
    function [9:0] word_index;
        input [11:0] byteAddr;
        begin
            word_index = byteAddr[11:2];
        end
    endfunction

    // true when a request index matches one register
    function reg_hit;
        input [9:0] idx;
        input [9:0] target;
        begin
            reg_hit = (idx == target);
        end
    endfunction

    // true in the capture cycle of one fuse slot
    function slot_hit;
        input capt;
        input [2:0] addr;
        input [2:0] slot;
        begin
            slot_hit = capt & (addr == slot);
        end
    endfunction

    assign regIdx = word_index(wbAdr);
    // a request is answered only once the fuse copy is done
    assign reqLive = wbCyc & wbStb & ~wbAck & loadDone;
    assign wrEn = reqLive & wbWe & wbSel[0];

    // fuse value is sampled in the second cycle of each slot
    assign fuseCapt = (state == ST_CAPT);

    // one write strobe per register, lane 0 only
    // a write without lane 0 is still answered but changes nothing
    assign wrGainB = wrEn & reg_hit(regIdx, `TDC_IDX_GAIN_B);
    assign wrRefTrim = wrEn & reg_hit(regIdx, `TDC_IDX_REF_TRIM);
    assign wrTermA = wrEn & reg_hit(regIdx, `TDC_IDX_TERM_A);
    assign wrTermB = wrEn & reg_hit(regIdx, `TDC_IDX_TERM_B);
    assign wrDither = wrEn & reg_hit(regIdx, `TDC_IDX_DITHER);
    assign wrSkew = wrEn & reg_hit(regIdx, `TDC_IDX_BANK0_SKEW);

    // next state of the load sequencer
    always @* begin
        next_state = state;
        case (state)
            ST_ADDR: begin
                next_state = ST_CAPT;
            end
            ST_CAPT: begin
                if (fuseAddr == `TDC_FUSE_LAST) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_ADDR;
                end
            end
            ST_IDLE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // sequencer state
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_ADDR;
        end else if (coreEn) begin
            state <= next_state;
        end
    end

    // fuse slot address, steps once per captured slot and parks on the last
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fuseAddr <= `TDC_FUSE_GAIN_B;
        end else if (coreEn && fuseCapt && fuseAddr != `TDC_FUSE_LAST) begin
            fuseAddr <= fuseAddr + 3'h1;
        end
    end

    // done flag, set with the last capture and kept until reset
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            loadDone <= 1'b0;
        end else if (coreEn && slot_hit(fuseCapt, fuseAddr, `TDC_FUSE_LAST)) begin
            loadDone <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // trim and timing registers: fuse value first, then software
    // ---------------------------------------------------------------
    // a capture and a software write never meet: writes wait for loadDone

    // channel B gain trim, fuse slot 0
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            channelBGainTrim <= 8'h00;
        end else if (coreEn) begin
            if (slot_hit(fuseCapt, fuseAddr, `TDC_FUSE_GAIN_B)) begin
                channelBGainTrim <= fuseData;
            end else if (wrGainB) begin
                channelBGainTrim <= wbDatIn[7:0];
            end
        end
    end

    // reference trim, fuse slot 1, low nibble only
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            referenceVoltageAdjust <= 4'h0;
        end else if (coreEn) begin
            if (slot_hit(fuseCapt, fuseAddr, `TDC_FUSE_REF_TRIM)) begin
                referenceVoltageAdjust <= fuseData[`TDC_REF_TRIM_MSB:0];
            end else if (wrRefTrim) begin
                referenceVoltageAdjust <= wbDatIn[`TDC_REF_TRIM_MSB:0];
            end
        end
    end

    // input A termination trim, fuse slot 2
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            inputATerminationAdjust <= 8'h00;
        end else if (coreEn) begin
            if (slot_hit(fuseCapt, fuseAddr, `TDC_FUSE_TERM_A)) begin
                inputATerminationAdjust <= fuseData;
            end else if (wrTermA) begin
                inputATerminationAdjust <= wbDatIn[7:0];
            end
        end
    end

    // input B termination trim, fuse slot 3
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            inputBTerminationAdjust <= 8'h00;
        end else if (coreEn) begin
            if (slot_hit(fuseCapt, fuseAddr, `TDC_FUSE_TERM_B)) begin
                inputBTerminationAdjust <= fuseData;
            end else if (wrTermB) begin
                inputBTerminationAdjust <= wbDatIn[7:0];
            end
        end
    end

    // bank zero skew, fuse slot 4
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bankZeroPhaseZeroSkew <= 8'h00;
        end else if (coreEn) begin
            if (slot_hit(fuseCapt, fuseAddr, `TDC_FUSE_BANK0_SKEW)) begin
                bankZeroPhaseZeroSkew <= fuseData;
            end else if (wrSkew) begin
                bankZeroPhaseZeroSkew <= wbDatIn[7:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // dither control register
    // ---------------------------------------------------------------
    // dither enable, on out of reset
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ditherOn <= DITHER_RESET[`TDC_DITH_ON_BIT];
        end else if (coreEn && wrDither) begin
            ditherOn <= wbDatIn[`TDC_DITH_ON_BIT];
        end
    end

    // dither amplitude: 0 small, 1 large
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ditherLevelSel <= DITHER_RESET[`TDC_DITH_LEVEL_BIT];
        end else if (coreEn && wrDither) begin
            ditherLevelSel <= wbDatIn[`TDC_DITH_LEVEL_BIT];
        end
    end

    // rounding error route: 0 into noise, 1 into offset and spurs
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            roundingErrorSel <= DITHER_RESET[`TDC_DITH_ROUND_BIT];
        end else if (coreEn && wrDither) begin
            roundingErrorSel <= wbDatIn[`TDC_DITH_ROUND_BIT];
        end
    end

    // ---------------------------------------------------------------
    // read mux and bus answer
    // ---------------------------------------------------------------
    always @* begin
        readByte = 8'h00;
        case (regIdx)
            `TDC_IDX_GAIN_B: begin
                readByte = channelBGainTrim;
            end
            `TDC_IDX_REF_TRIM: begin
                readByte = {4'h0, referenceVoltageAdjust};
            end
            `TDC_IDX_TERM_A: begin
                readByte = inputATerminationAdjust;
            end
            `TDC_IDX_TERM_B: begin
                readByte = inputBTerminationAdjust;
            end
            `TDC_IDX_DITHER: begin
                readByte = {5'h00, roundingErrorSel, ditherLevelSel, ditherOn};
            end
            `TDC_IDX_BANK0_SKEW: begin
                readByte = bankZeroPhaseZeroSkew;
            end
            default: begin
                readByte = 8'h00; // unmapped reads zero
            end
        endcase
    end

    // one-cycle ack; the ~wbAck term blocks a new ack in the cycle right after an ack
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wbAck <= 1'b0;
        end else if (coreEn) begin
            wbAck <= reqLive;
        end
    end

    // read data, held until the next read answer
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wbDatOut <= 32'h00000000;
        end else if (coreEn && reqLive && !wbWe) begin
            wbDatOut <= {24'h000000, readByte};
        end
    end

endmodule

// ---- verification/tdc_regs_chk.sv ----
`timescale 1ns/10ps
module tdc_regs_chk (
    input wire core_clk,
    input wire reset_n,
    input wire coreEn,
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [11:0] wbAdr,
    input wire [3:0] wbSel,
    input wire [31:0] wbDatIn,
    input wire [31:0] wbDatOut,
    input wire wbAck,
    input wire loadDone,
    input wire [7:0] channelBGainTrim,
    input wire ditherOn,
    input wire ditherLevelSel,
    input wire roundingErrorSel
);
    // request taken by the slice, read answer on the bus
    wire take = coreEn & wbCyc & wbStb & ~wbAck & loadDone;
    wire rd = wbAck & ~wbWe;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    chk_ack_pulse: assert property (wbAck && coreEn |=> !wbAck) else $error("ack long");
    chk_ack_early: assert property (wbAck |-> $past(loadDone)) else $error("ack early");
    chk_ack_answer: assert property (take |=> wbAck) else $error("no ack");
    chk_load_stays: assert property (loadDone |=> loadDone) else $error("load lost");
    chk_dither_reset: assert property ($rose(reset_n) |-> ditherOn) else $error("dither");
    chk_ref_upper: assert property (rd && wbAdr[11:2] == 10'h07C |-> wbDatOut[31:4] == 28'h0)
        else $error("ref upper");
    chk_dither_read: assert property (rd && wbAdr[11:2] == 10'h09D |-> wbDatOut ==
        {29'h0, roundingErrorSel, ditherLevelSel, ditherOn}) else $error("dither read");
    chk_gain_write: assert property (take && wbWe && wbSel[0] && wbAdr[11:2] == 10'h07B |=>
        channelBGainTrim == $past(wbDatIn[7:0])) else $error("gain write");
endmodule
bind tdc_trim_dither_config_regs tdc_regs_chk i_chk (.core_clk(core_clk), .reset_n(reset_n),
    .coreEn(coreEn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .loadDone(loadDone),
    .channelBGainTrim(channelBGainTrim), .ditherOn(ditherOn), .ditherLevelSel(ditherLevelSel),
    .roundingErrorSel(roundingErrorSel));

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0, reset_n = 1'b0, coreEn = 1'b1, wbCyc = 1'b0, wbStb = 1'b0;
    logic wbWe = 1'b0, wbAck, loadDone, ditherOn, ditherLevelSel, roundingErrorSel;
    logic [11:0] wbAdr = 12'h000;
    logic [3:0] wbSel = 4'h0, referenceVoltageAdjust;
    logic [31:0] wbDatIn = 32'h00000000, wbDatOut, q;
    logic [2:0] fuseAddr;
    logic [7:0] fuseData, channelBGainTrim, inputATerminationAdjust, inputBTerminationAdjust;
    logic [7:0] bankZeroPhaseZeroSkew;
    int errors = 0, cmp_count = 0;
    logic [11:0] adr [6] = '{12'h1EC, 12'h1F0, 12'h1F8, 12'h1FC, 12'h274, 12'h408};
    logic [7:0] msk [6] = '{8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h07, 8'hFF};
    logic [7:0] fz [5] = '{8'hC3, 8'hE6, 8'h89, 8'hAC, 8'h57};
    // fuse storage with arbitrary contents, answers from its slot address
    assign fuseData = fz[fuseAddr];
    tdc_trim_dither_config_regs i_dut (.core_clk(core_clk), .reset_n(reset_n), .coreEn(coreEn),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
        .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .fuseAddr(fuseAddr),
        .fuseData(fuseData), .loadDone(loadDone), .channelBGainTrim(channelBGainTrim),
        .referenceVoltageAdjust(referenceVoltageAdjust),
        .inputATerminationAdjust(inputATerminationAdjust),
        .inputBTerminationAdjust(inputBTerminationAdjust), .ditherOn(ditherOn),
        .ditherLevelSel(ditherLevelSel), .roundingErrorSel(roundingErrorSel),
        .bankZeroPhaseZeroSkew(bankZeroPhaseZeroSkew));
    initial forever #10 core_clk = ~core_clk;
    task automatic ck(string nm, logic [31:0] e, logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wb(logic we, logic [3:0] sel, logic [11:0] a, logic [7:0] d);
        int n = 0;
        {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatIn} <= {2'b11, we, sel, a, 24'h000000, d};
        @(posedge core_clk);
        while (wbAck !== 1'b1 && n++ < 40) @(posedge core_clk);
        if (wbAck !== 1'b1) begin
            errors++;
            $display("BAD ack exp 1 got %b", wbAck);
        end
        q = wbDatOut;
        {wbCyc, wbStb} <= 2'b00;
        @(posedge core_clk);
    endtask
    task automatic rd(logic [11:0] a, logic [7:0] e, string nm);
        wb(1'b0, 4'h0, a, 8'h00);
        ck(nm, {24'h0, e}, q);
    endtask
    task automatic t_start;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (9) @(posedge core_clk);
        #1 ck("load early", 32'h0, {31'h0, loadDone});
        @(posedge core_clk);
        #1 ck("load done", 32'h1, {31'h0, loadDone});
        ck("gain port", {24'h0, fz[0]}, {24'h0, channelBGainTrim});
        ck("ref port", {28'h0, fz[1][3:0]}, {28'h0, referenceVoltageAdjust});
        ck("term a port", {24'h0, fz[2]}, {24'h0, inputATerminationAdjust});
        ck("term b port", {24'h0, fz[3]}, {24'h0, inputBTerminationAdjust});
        ck("skew port", {24'h0, fz[4]}, {24'h0, bankZeroPhaseZeroSkew});
        ck("dither port", 32'h1, {29'h0, roundingErrorSel, ditherLevelSel, ditherOn});
        ck("fuse slot", 32'h4, {29'h0, fuseAddr});
        @(posedge core_clk);
        foreach (adr[i])
            rd(adr[i], i == 4 ? 8'h01 : fz[i - i / 5] & msk[i], "rst");
    endtask
    task automatic t_rw;
        foreach (adr[i]) begin
            wb(1'b1, 4'h1, adr[i], 8'h96);
            rd(adr[i], msk[i] & 8'h96, "wr");
        end
        ck("trim ports", 32'h96969696, {channelBGainTrim, inputATerminationAdjust,
            inputBTerminationAdjust, bankZeroPhaseZeroSkew});
        ck("ref dither", 32'h66, {24'h0, referenceVoltageAdjust, 1'b0,
            roundingErrorSel, ditherLevelSel, ditherOn});
        wb(1'b1, 4'hE, 12'h1F8, 8'h33);
        rd(12'h1F8, 8'h96, "lane off");
        wb(1'b1, 4'hF, 12'h1F4, 8'h33);
        rd(12'h1F4, 8'h00, "unmapped");
    endtask
    // clock enable low: a standing request gets no answer and nothing moves
    task automatic t_hold;
        coreEn <= 1'b0;
        {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatIn} <= {3'h7, 4'h1, 12'h1FC, 32'h0000005A};
        repeat (5) @(posedge core_clk);
        #1 ck("hold ack", 32'h0, {31'h0, wbAck});
        ck("hold reg", 32'h96, {24'h0, inputBTerminationAdjust});
        @(posedge core_clk);
        coreEn <= 1'b1;
        wb(1'b1, 4'h1, 12'h1FC, 8'h5A);
        rd(12'h1FC, 8'h5A, "hold write");
    endtask
    task automatic t_early;
        reset_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(12'h1EC, 8'hC3, "reload gain");
        rd(12'h274, 8'h01, "reload dither");
        rd(12'h1F0, 8'h06, "reload");
    endtask
    task automatic end_of_test;
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard
    initial begin
        #40us;
        errors++;
        $display("BAD watchdog exp done got timeout");
        end_of_test();
    end
    // scenario sequence
    initial begin
        t_start();
        t_rw();
        t_hold();
        t_early();
        end_of_test();
    end
endmodule
